// ### hdl/gcr_ctrl_bank.v
`timescale 1ns/100ps
`include "gcr_ctrl_regs.vh"
// ----------------------------------------
// Global control bank with two reduced MII receivers
// ----------------------------------------
module gcr_ctrl_bank (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire third_port_reduced_mii_ref_clk,
	input wire [1:0] third_port_reduced_mii_rxd,
	input wire third_port_reduced_mii_crs_dv,
	input wire fourth_port_reduced_mii_ref_clk,
	input wire [1:0] fourth_port_reduced_mii_rxd,
	input wire fourth_port_reduced_mii_crs_dv,
	output wire [7:0] third_switch_mac_rx_byte,
	output wire third_switch_mac_rx_valid,
	output wire [7:0] fourth_switch_mac_rx_byte,
	output wire fourth_switch_mac_rx_valid,
	output reg phy_power_save_en
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg third_edge_reg;
	reg fourth_edge_reg;
	reg ps_disable_reg;
	wire [5:0] idx;
	wire addr_ok;
	wire access;
	wire commit;
	reg [31:0] rdata_next;
	reg err_next;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function is_reg;
		input [11:0] addr;
		input [5:0] index;
		begin
			is_reg = (addr[11:8] == 4'h0) && (addr[1:0] == 2'h0) &&
				(addr[7:2] == index);
		end
	endfunction

	function mapped;
		input [11:0] addr;
		begin
			mapped = is_reg(addr, `GCR_IDX_FACTORY_TEST_A) ||
				is_reg(addr, `GCR_IDX_FACTORY_TEST_B) ||
				is_reg(addr, `GCR_IDX_FACTORY_TEST_C) ||
				is_reg(addr, `GCR_IDX_EDGE_PS_CTRL) ||
				is_reg(addr, `GCR_IDX_LINK_STATUS);
		end
	endfunction

	assign idx = paddr[7:2];
	assign addr_ok = mapped(paddr);
	// One wait state: answer prepared in first access cycle
	assign access = psel & penable & ~pready;
	assign commit = psel & penable & pready;

	// ----------------------------------------
	// Receive samplers
	// ----------------------------------------
	wire [3:0] dibits;
	wire [1:0] dvs;
	wire [1:0] strobes;

	gcr_edge_sampler u_third (
		.pclk(pclk),
		.presetn(presetn),
		.ref_clk(third_port_reduced_mii_ref_clk),
		.rxd(third_port_reduced_mii_rxd),
		.crs_dv(third_port_reduced_mii_crs_dv),
		.falling_sel(third_edge_reg),
		.dibit_reg(dibits[1:0]),
		.dv_reg(dvs[0]),
		.strobe_reg(strobes[0])
	);

	gcr_edge_sampler u_fourth (
		.pclk(pclk),
		.presetn(presetn),
		.ref_clk(fourth_port_reduced_mii_ref_clk),
		.rxd(fourth_port_reduced_mii_rxd),
		.crs_dv(fourth_port_reduced_mii_crs_dv),
		.falling_sel(fourth_edge_reg),
		.dibit_reg(dibits[3:2]),
		.dv_reg(dvs[1]),
		.strobe_reg(strobes[1])
	);

	// ----------------------------------------
	// Dibit to byte assembly, low dibit first
	// ----------------------------------------
	// Per-lane registers keep each flip-flop to a single process
	wire [15:0] byte_vec;
	wire [1:0] valid_vec;
	wire [1:0] dv_seen_vec;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : asm
			reg [1:0] cnt_reg;
			reg [7:0] shift_reg;
			reg [7:0] byte_reg;
			reg valid_reg;
			reg dv_seen_reg;
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					cnt_reg <= 2'h0;
					shift_reg <= 8'h00;
					byte_reg <= 8'h00;
					valid_reg <= 1'b0;
					dv_seen_reg <= 1'b0;
				end
				else
				begin
					valid_reg <= 1'b0;
					if (strobes[g])
					begin
						dv_seen_reg <= dvs[g];
						if (dvs[g])
						begin
							shift_reg <= {dibits[2*g+1:2*g], shift_reg[7:2]};
							cnt_reg <= cnt_reg + 2'h1;
							if (cnt_reg == `GCR_DIBITS_PER_BYTE)
							begin
								byte_reg <=
									{dibits[2*g+1:2*g], shift_reg[7:2]};
								valid_reg <= 1'b1;
							end
						end
						else
						begin
							// Idle line realigns the next byte
							cnt_reg <= 2'h0;
						end
					end
				end
			end
			assign byte_vec[8*g+7:8*g] = byte_reg;
			assign valid_vec[g] = valid_reg;
			assign dv_seen_vec[g] = dv_seen_reg;
		end
	endgenerate

	assign third_switch_mac_rx_byte = byte_vec[7:0];
	assign third_switch_mac_rx_valid = valid_vec[0];
	assign fourth_switch_mac_rx_byte = byte_vec[15:8];
	assign fourth_switch_mac_rx_valid = valid_vec[1];

	// ----------------------------------------
	// Control register writes
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			third_edge_reg <= `GCR_RST_EDGE_SEL;
			fourth_edge_reg <= `GCR_RST_EDGE_SEL;
			ps_disable_reg <= `GCR_RST_PS_DISABLE;
		end
		else if (commit && pwrite && is_reg(paddr, `GCR_IDX_EDGE_PS_CTRL))
		begin
			third_edge_reg <= pwdata[`GCR_BIT_THIRD_EDGE];
			fourth_edge_reg <= pwdata[`GCR_BIT_FOURTH_EDGE];
			ps_disable_reg <= pwdata[`GCR_BIT_PS_DISABLE];
			// Bits 5 and 4 are not stored, so writes cannot disturb them
		end
	end

	// Power save is on whenever the disable bit is clear
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phy_power_save_en <= 1'b1;
		else
			phy_power_save_en <= ~ps_disable_reg;
	end

	// ----------------------------------------
	// Read mux
	// ----------------------------------------
	always @*
	begin
		rdata_next = 32'h00000000;
		err_next = 1'b0;
		if (!addr_ok)
			err_next = 1'b1;
		else if (pwrite)
			rdata_next = 32'h00000000;
		else if (idx == `GCR_IDX_FACTORY_TEST_A)
			rdata_next[7:0] = `GCR_RST_FACTORY_TEST_A;
		else if (idx == `GCR_IDX_FACTORY_TEST_B)
			rdata_next[7:0] = `GCR_RST_FACTORY_TEST_B;
		else if (idx == `GCR_IDX_FACTORY_TEST_C)
			rdata_next[7:0] = `GCR_RST_FACTORY_TEST_C;
		else if (idx == `GCR_IDX_EDGE_PS_CTRL)
			rdata_next[7:0] = {third_edge_reg, fourth_edge_reg,
				`GCR_RST_RESERVED_5_4, ps_disable_reg, 3'h0};
		else
			rdata_next[3:0] = {dv_seen_vec, dvs};
	end

	// ----------------------------------------
	// APB answer, all from flip-flops
	// ----------------------------------------
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (access)
		begin
			prdata <= rdata_next;
			pready <= 1'b1;
			pslverr <= err_next;
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule

// ### hdl/gcr_ctrl_regs.vh
// Functional notes
// - Control bit 7 set: third port samples receive data on falling edge.
// - Edge-select bit clear, its reset value: sample on rising edge.
// - Bit 6 picks fourth port edge alone; 1 falling, 0 rising, reset 0.
// - Control bit 3 written 1 disables power save on all integrated PHYs.
// - Power-save bit at 0, its reset value, keeps power save enabled.
`ifndef GCR_CTRL_REGS_VH
`define GCR_CTRL_REGS_VH

// ----------------------------------------
// Register indices, byte address is four times
// ----------------------------------------
`define GCR_IDX_FACTORY_TEST_A 6'h08
`define GCR_IDX_FACTORY_TEST_B 6'h09
`define GCR_IDX_FACTORY_TEST_C 6'h0A
`define GCR_IDX_EDGE_PS_CTRL 6'h0B
`define GCR_IDX_LINK_STATUS 6'h0C

// ----------------------------------------
// Reset and fixed read values
// ----------------------------------------
`define GCR_RST_FACTORY_TEST_A 8'h00
`define GCR_RST_FACTORY_TEST_B 8'h4C
`define GCR_RST_FACTORY_TEST_C 8'h00
`define GCR_RST_EDGE_SEL 1'h0
`define GCR_RST_PS_DISABLE 1'h0
`define GCR_RST_RESERVED_5_4 2'h0

// ----------------------------------------
// Field positions in the control register
// ----------------------------------------
`define GCR_BIT_THIRD_EDGE 7
`define GCR_BIT_FOURTH_EDGE 6
`define GCR_BIT_PS_DISABLE 3

// ----------------------------------------
// Timing
// ----------------------------------------
`define GCR_DIBITS_PER_BYTE 2'h3

`endif

// ### hdl/gcr_sync.v
`timescale 1ns/100ps
// ----------------------------------------
// Two-stage synchroniser
// ----------------------------------------
module gcr_sync #(
	parameter WIDTH = 1
) (
	input wire pclk,
	input wire presetn,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// ### hdl/gcr_edge_sampler.v
`timescale 1ns/100ps
// ----------------------------------------
// Reduced MII receive sampler on chosen edge
// ----------------------------------------
module gcr_edge_sampler (
	input wire pclk,
	input wire presetn,
	input wire ref_clk,
	input wire [1:0] rxd,
	input wire crs_dv,
	input wire falling_sel,
	output reg [1:0] dibit_reg,
	output reg dv_reg,
	output reg strobe_reg
);
	wire [3:0] sync_vec;
	reg ref_d_reg;
	reg [2:0] data_d_reg;
	wire rise;
	wire fall;
	wire take;

	gcr_sync #(.WIDTH(4)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({ref_clk, crs_dv, rxd}),
		.sync_out(sync_vec)
	);

	// Data held one stage back so it is the value just before the edge
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_d_reg <= 1'b0;
			data_d_reg <= 3'h0;
		end
		else
		begin
			ref_d_reg <= sync_vec[3];
			data_d_reg <= sync_vec[2:0];
		end
	end

	assign rise = sync_vec[3] & ~ref_d_reg;
	assign fall = ~sync_vec[3] & ref_d_reg;
	assign take = falling_sel ? fall : rise;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			dibit_reg <= 2'h0;
			dv_reg <= 1'b0;
			strobe_reg <= 1'b0;
		end
		else
		begin
			strobe_reg <= take;
			if (take)
			begin
				dibit_reg <= data_d_reg[1:0];
				dv_reg <= data_d_reg[2];
			end
		end
	end
endmodule

// ### verif/gcr_bank_asserts.sv
`timescale 1ns/100ps
// ------------------------------
// Bank port checks
// ------------------------------
module gcr_bank_asserts (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire third_switch_mac_rx_valid,
	input wire phy_power_save_en
);
	wire rd = psel & penable & pready & !pwrite;
	wire wr_c = psel & penable & pready & pwrite & (paddr == 12'h02C);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	save_on_rst_a: assert property (
		$rose(presetn) |-> phy_power_save_en) else $error("save off at reset");
	// Two edges covers either output register placement
	save_write_a: assert property (wr_c |-> ##2
		phy_power_save_en == !$past(pwdata[3], 2)) else $error("save wrong");
	save_hold_a: assert property (!wr_c ##1 !wr_c |=>
		$stable(phy_power_save_en)) else $error("save moved");
	test_b_read_a: assert property (rd && paddr == 12'h024 |->
		prdata == 32'h0000004C) else $error("test b value");
	test_ac_read_a: assert property (rd &&
		(paddr == 12'h020 || paddr == 12'h028) |->
		prdata == 32'h0) else $error("test a or c value");
	ctrl_bits_a: assert property (rd && paddr == 12'h02C |->
		prdata[31:8] == 24'h0 && prdata[5:4] == 2'h0 &&
		prdata[3] == !phy_power_save_en) else $error("control bits");
	rx_pulse_a: assert property (third_switch_mac_rx_valid |=>
		!third_switch_mac_rx_valid) else $error("valid not a pulse");
	cover property (wr_c && pwdata[3]);
	cover property (rd && pslverr);
	cover property (third_switch_mac_rx_valid);
endmodule

bind gcr_ctrl_bank gcr_bank_asserts gcr_bank_asserts_i (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .phy_power_save_en(phy_power_save_en),
	.third_switch_mac_rx_valid(third_switch_mac_rx_valid));

// ### verif/gcr_rmii_peer.sv
`timescale 1ns/100ps
// ------------------------------
// Far-side MAC, one frame per call
// ------------------------------
module gcr_rmii_peer (
	output logic ref_clk,
	output logic [1:0] rxd,
	output logic crs_dv
);
	initial
	begin
		ref_clk = 0;
		rxd = 2'h0;
		crs_dv = 0;
	end
	// Data launched on the edge opposite the sampling one
	task automatic send(input logic [15:0] d, input logic neg);
		#1.3;
		for (int i = 0; i < 9; i++)
		begin
			ref_clk = neg;
			crs_dv = i < 8;
			rxd = (i < 8) ? d[2*i +: 2] : ~rxd;
			#32 ref_clk = !neg;
			#32;
		end
		ref_clk = 0;
	endtask
endmodule

// ### verif/testbench.sv
`timescale 1ns/100ps
// ------------------------------
// Bank bench
// ------------------------------
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic ps_en, rc3, cd3, rc4, cd4, v3, v4;
	logic [1:0] rx3, rx4;
	logic [7:0] b3, b4;
	logic [15:0] d3, d4;
	logic [7:0] q3[$], q4[$];
	logic [11:0] ra[8] = '{12'h020, 12'h024, 12'h028, 12'h02C, 12'h100,
		12'h02D, 12'h034, 12'h030};
	int errors, total_checks, ctrl_m;
	gcr_ctrl_bank gcr_ctrl_bank_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.third_port_reduced_mii_ref_clk(rc3), .third_port_reduced_mii_rxd(rx3),
		.third_port_reduced_mii_crs_dv(cd3), .fourth_port_reduced_mii_rxd(rx4),
		.fourth_port_reduced_mii_ref_clk(rc4), .fourth_port_reduced_mii_crs_dv(cd4),
		.third_switch_mac_rx_byte(b3), .third_switch_mac_rx_valid(v3),
		.fourth_switch_mac_rx_byte(b4), .fourth_switch_mac_rx_valid(v4),
		.phy_power_save_en(ps_en));
	gcr_rmii_peer peer3_i (.ref_clk(rc3), .rxd(rx3), .crs_dv(cd3));
	gcr_rmii_peer peer4_i (.ref_clk(rc4), .rxd(rx4), .crs_dv(cd4));
	initial
	begin
		pclk = 0;
		forever #2 pclk = ~pclk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1 && n < 40);
		if (pready !== 1)
		begin
			errors++;
			results;
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
		if (w && a == 12'h02C)
			ctrl_m = d & 32'hC8;
		@(posedge pclk);
	endtask
	task rd_chk(input logic [11:0] a);
		apb(0, a, 32'h0);
		chk(rdat, a == 12'h024 ? 32'h4C : a == 12'h02C ? ctrl_m : 0);
		chk(rerr, !(a inside {12'h020, 12'h024, 12'h028, 12'h02C,
			12'h030}));
	endtask
	always @(posedge pclk)
	begin
		if (v3 === 1)
			chk(b3, q3.size() ? q3.pop_front() : 8'hXX);
		if (v4 === 1)
			chk(b4, q4.size() ? q4.pop_front() : 8'hXX);
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = 0;
		{ctrl_m, errors, total_checks} = 0;
		void'($urandom(34675));
		repeat (16) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		chk(ps_en, 1);
		foreach (ra[i]) rd_chk(ra[i]);
		repeat (20)
		begin
			apb(1, ra[$urandom % 8], $urandom);
			rd_chk(12'h02C);
			chk(ps_en, !ctrl_m[3]);
		end
		// Every edge pairing, both ports at once
		for (int k = 0; k < 4; k++)
		begin
			apb(1, 12'h02C, {24'h0, 2'(k), 6'($urandom)});
			d3 = 16'($urandom);
			d4 = 16'($urandom);
			q3 = '{d3[7:0], d3[15:8]};
			q4 = '{d4[7:0], d4[15:8]};
			fork
				peer3_i.send(d3, k[1]);
				peer4_i.send(d4, k[0]);
			join
			repeat (20) @(posedge pclk);
			chk(q3.size() + q4.size(), 0);
		end
		results;
	end
endmodule
